//--- src/maskable_interrupt_control.sv
// Interrupt control end: control registers, flags, acceptance, entry
//
// Overview of operation
// - Enable flag gates all maskables; reset clears it
// - Gating never touches non-maskable software interrupts
// - Per-source control registers; flags hold enable, threshold
// - Source request sets its pending bit
// - Writing zero clears pending; never write one
// - Three-bit level, zero disables, seven highest
// - Accept needs enable, pending, level above threshold
// - Threshold n admits only levels above n
// - Enable, pending, level, threshold stored independently
// - Rewrite control register only with interrupts disabled
// - Settle gap before re-enabling after rewrite
// - Masked logic writes preserve concurrent requests
// - Move writes of zero clear the pending bit even against a concurrent request
// - Resolve at instruction end, enter next cycle
// - String and repeat instructions suspend for entry
// - Acknowledge read at zero; pending clears on the same edge
// - Copy pre-sequence flags into hidden temporary
// - Clear enable, trace, stack select; keep for 32-63
// - Push flag copy, then program counter
// - Load accepted level into threshold
// - Jump to routine start after entry
// - Equal levels resolved by fixed hardware order
// - Vector at base plus four times number
`timescale 1ns/1ps
module maskable_interrupt_control (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [mic_pkg::NSRC-1:0] src_req_i,
  output logic [mic_pkg::NSRC-1:0] src_pend_o,
  output logic busy_o,
  mic_if.ctl ifc
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [mic_pkg::NSRC-1:0][mic_pkg::CREG_W-1:0] creg_q, creg_d;
  logic [mic_pkg::FLG_W-1:0] flg_q, flg_d;
  logic [mic_pkg::FLG_W-1:0] tmp_q, tmp_d;
  mic_pkg::mic_seq_e seq_q, seq_d;
  logic [mic_pkg::IDX_W-1:0] sel_q, sel_d;
  logic [mic_pkg::NUM_W-1:0] num_q, num_d;
  logic [mic_pkg::LVL_W-1:0] lvl_q, lvl_d;
  logic swi_q, swi_d;
  logic take_q, take_d;
  logic ack_q, ack_d;
  logic push_q, push_d;
  logic [mic_pkg::ADDR_W-1:0] pdat_q, pdat_d;
  logic vrd_q, vrd_d;
  logic [mic_pkg::ADDR_W-1:0] vaddr_q, vaddr_d;
  logic [mic_pkg::ADDR_W-1:0] vdat_q, vdat_d;
  logic jump_q, jump_d;
  logic [mic_pkg::ADDR_W-1:0] jaddr_q, jaddr_d;
  logic busy_q, busy_d;

  logic hit;
  logic [mic_pkg::IDX_W-1:0] hit_idx;
  logic [mic_pkg::LVL_W-1:0] hit_lvl;
  logic ack_clr;
  logic bound;
  logic keep_u;

  // ----------------------------------------------------------------
  // Resolver
  // ----------------------------------------------------------------
  mic_resolve mic_resolve_inst (
    .creg_i(creg_q),
    .ien_i(flg_q[mic_pkg::FLG_I]),
    .ipl_i(flg_q[mic_pkg::IPL_LSB +: mic_pkg::LVL_W]),
    .hit_o(hit),
    .idx_o(hit_idx),
    .lvl_o(hit_lvl)
  );

  // Hardware clears the accepted source in the acknowledge step
  assign ack_clr = (seq_q == mic_pkg::SEQ_ACK) && !swi_q;
  // String and repeat instructions offer a boundary every cycle
  assign bound = ifc.instr_done | ifc.string_run;
  // Software interrupts 32 to 63 keep the stack select flag
  assign keep_u = swi_q && (num_q >= mic_pkg::SWI_USP_LO) &&
    (num_q <= mic_pkg::SWI_USP_HI);

  // ----------------------------------------------------------------
  // Per-source control registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < mic_pkg::NSRC; g++) begin : g_creg
      logic wr_hit;
      logic req_clr;
      assign wr_hit = ifc.creg_wr &&
        (ifc.creg_idx == mic_pkg::IDX_W'(g));
      // A masked write of zero clears; a one leaves the bit alone
      assign req_clr = (wr_hit && ifc.creg_wmask[mic_pkg::REQ_BIT] &&
        !ifc.creg_wdata[mic_pkg::REQ_BIT]) ||
        (ack_clr && sel_q == mic_pkg::IDX_W'(g));

      always_comb begin
        creg_d[g] = creg_q[g];
        if (wr_hit) begin
          // Only masked bits change; level and pending are separate
          creg_d[g] = (creg_q[g] & ~ifc.creg_wmask) |
            (ifc.creg_wdata & ifc.creg_wmask);
        end
        creg_d[g][mic_pkg::REQ_BIT] = creg_q[g][mic_pkg::REQ_BIT];
        if (req_clr) begin
          creg_d[g][mic_pkg::REQ_BIT] = 1'b0;
        end
        if (src_req_i[g] && !(wr_hit && ifc.creg_move && req_clr)) begin
          // Set beats clear, except a move write that clears
          creg_d[g][mic_pkg::REQ_BIT] = 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags and entry sequence, next values
  // ----------------------------------------------------------------
  always_comb begin
    flg_d = flg_q;
    tmp_d = tmp_q;
    seq_d = seq_q;
    sel_d = sel_q;
    num_d = num_q;
    lvl_d = lvl_q;
    swi_d = swi_q;
    take_d = 1'b0;
    ack_d = 1'b0;
    push_d = 1'b0;
    pdat_d = pdat_q;
    vrd_d = 1'b0;
    vaddr_d = vaddr_q;
    vdat_d = vdat_q;
    jump_d = 1'b0;
    jaddr_d = jaddr_q;
    busy_d = busy_q;
    // Software flag writes touch only the masked bits
    if (ifc.flg_wr && seq_q == mic_pkg::SEQ_IDLE) begin
      flg_d = (flg_q & ~ifc.flg_wmask) |
        (ifc.flg_wdata & ifc.flg_wmask);
    end
    unique case (seq_q)
      mic_pkg::SEQ_IDLE: begin
        if (ifc.swi_req && ifc.instr_done) begin
          // Software interrupts bypass enable, pending and threshold
          swi_d = 1'b1;
          num_d = ifc.swi_num;
          take_d = 1'b1;
          busy_d = 1'b1;
          seq_d = mic_pkg::SEQ_ACK;
        end else if (hit && bound) begin
          swi_d = 1'b0;
          sel_d = hit_idx;
          lvl_d = hit_lvl;
          num_d = mic_pkg::SRC_NUM_BASE + mic_pkg::NUM_W'(hit_idx);
          take_d = 1'b1;
          busy_d = 1'b1;
          seq_d = mic_pkg::SEQ_ACK;
        end
      end
      mic_pkg::SEQ_ACK: begin
        ack_d = !swi_q;
        seq_d = mic_pkg::SEQ_SAVE;
      end
      mic_pkg::SEQ_SAVE: begin
        // Flags are untouched until here, so this is the old value
        tmp_d = flg_q;
        seq_d = mic_pkg::SEQ_CLR;
      end
      mic_pkg::SEQ_CLR: begin
        flg_d[mic_pkg::FLG_I] = 1'b0;
        flg_d[mic_pkg::FLG_D] = 1'b0;
        if (!keep_u) begin
          flg_d[mic_pkg::FLG_U] = 1'b0;
        end
        seq_d = mic_pkg::SEQ_PUSHF;
      end
      mic_pkg::SEQ_PUSHF: begin
        push_d = 1'b1;
        pdat_d = {{(mic_pkg::ADDR_W - mic_pkg::FLG_W){1'b0}}, tmp_q};
        seq_d = mic_pkg::SEQ_PUSHPC;
      end
      mic_pkg::SEQ_PUSHPC: begin
        push_d = 1'b1;
        pdat_d = ifc.pc;
        vrd_d = 1'b1;
        vaddr_d = ifc.vec_base + {{(mic_pkg::ADDR_W - mic_pkg::NUM_W -
          mic_pkg::VEC_SHIFT){1'b0}}, num_q,
          {mic_pkg::VEC_SHIFT{1'b0}}};
        seq_d = mic_pkg::SEQ_VEC;
      end
      mic_pkg::SEQ_VEC: begin
        // Waits as long as the core takes to return the vector
        if (ifc.vec_ack) begin
          vdat_d = ifc.vec_data;
          seq_d = mic_pkg::SEQ_SETIPL;
        end
      end
      mic_pkg::SEQ_SETIPL: begin
        if (!swi_q) begin
          flg_d[mic_pkg::IPL_LSB +: mic_pkg::LVL_W] = lvl_q;
        end
        jump_d = 1'b1;
        jaddr_d = vdat_q;
        busy_d = 1'b0;
        seq_d = mic_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      creg_q <= {mic_pkg::NSRC{mic_pkg::CREG_RST}};
      flg_q <= mic_pkg::FLG_RST;
      tmp_q <= mic_pkg::FLG_RST;
      seq_q <= mic_pkg::SEQ_IDLE;
      sel_q <= '0;
      num_q <= '0;
      lvl_q <= '0;
      swi_q <= 1'b0;
      take_q <= 1'b0;
      ack_q <= 1'b0;
      push_q <= 1'b0;
      pdat_q <= '0;
      vrd_q <= 1'b0;
      vaddr_q <= '0;
      vdat_q <= '0;
      jump_q <= 1'b0;
      jaddr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      creg_q <= creg_d;
      flg_q <= flg_d;
      tmp_q <= tmp_d;
      seq_q <= seq_d;
      sel_q <= sel_d;
      num_q <= num_d;
      lvl_q <= lvl_d;
      swi_q <= swi_d;
      take_q <= take_d;
      ack_q <= ack_d;
      push_q <= push_d;
      pdat_q <= pdat_d;
      vrd_q <= vrd_d;
      vaddr_q <= vaddr_d;
      vdat_q <= vdat_d;
      jump_q <= jump_d;
      jaddr_q <= jaddr_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flip-flops except the fixed acknowledge address
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < mic_pkg::NSRC; g++) begin : g_pend
      assign src_pend_o[g] = creg_q[g][mic_pkg::REQ_BIT];
    end
  endgenerate
  assign busy_o = busy_q;
  assign ifc.flag_register = flg_q;
  assign ifc.creg = creg_q;
  assign ifc.take = take_q;
  assign ifc.ack_rd = ack_q;
  assign ifc.ack_addr = mic_pkg::ACK_ADDR; // Fixed acknowledge address
  assign ifc.ack_num = num_q;
  assign ifc.ack_lvl = lvl_q;
  assign ifc.push_vld = push_q;
  assign ifc.push_data = pdat_q;
  assign ifc.vec_rd = vrd_q;
  assign ifc.vec_addr = vaddr_q;
  assign ifc.jump = jump_q;
  assign ifc.jump_addr = jaddr_q;
  assign ifc.busy = busy_q;
endmodule

//--- pkg/mic_pkg.sv
// Shared constants and types for the maskable interrupt control block
package mic_pkg;

  // ----------------------------------------------------------------
  // Sources and per-source control register layout
  // ----------------------------------------------------------------
  localparam int NSRC = 8;
  localparam int IDX_W = 3;
  localparam int CREG_W = 8;
  localparam int LVL_W = 3;
  localparam int LVL_LSB = 0;
  localparam int REQ_BIT = 3;
  localparam logic [CREG_W-1:0] CREG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Flag register layout
  // ----------------------------------------------------------------
  localparam int FLG_W = 16;
  localparam int FLG_I = 0;
  localparam int FLG_D = 1;
  localparam int FLG_U = 2;
  localparam int IPL_LSB = 4;
  localparam logic [FLG_W-1:0] FLG_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Addresses, vector table and interrupt numbers
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [ADDR_W-1:0] ACK_ADDR = 20'h00000;
  localparam int VEC_TBL_BYTES = 256;
  localparam int VEC_ENTRY_BYTES = 4;
  localparam int VEC_SHIFT = $clog2(VEC_ENTRY_BYTES);
  localparam int NUM_W = $clog2(VEC_TBL_BYTES / VEC_ENTRY_BYTES);
  localparam logic [NUM_W-1:0] SRC_NUM_BASE = 6'h04;
  localparam logic [NUM_W-1:0] SWI_USP_LO = 6'h20;
  localparam logic [NUM_W-1:0] SWI_USP_HI = 6'h3F;

  // ----------------------------------------------------------------
  // Software settle gap before re-enabling, in cycles
  // ----------------------------------------------------------------
  localparam int GAP_W = 3;
  localparam logic [GAP_W-1:0] GAP_NOP = 3'h2;
  localparam logic [GAP_W-1:0] GAP_NOP_HOLD = 3'h4;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b000,
    SEQ_ACK    = 3'b001,
    SEQ_SAVE   = 3'b010,
    SEQ_CLR    = 3'b011,
    SEQ_PUSHF  = 3'b100,
    SEQ_PUSHPC = 3'b101,
    SEQ_VEC    = 3'b110,
    SEQ_SETIPL = 3'b111
  } mic_seq_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_DIS  = 2'b01,
    H_WR   = 2'b10
  } mic_host_e;

endpackage

//--- pkg/mic_if.sv
// Link between the interrupt control end and the CPU core end
`timescale 1ns/1ps
interface mic_if;
  // Driven by the interrupt control end
  logic [mic_pkg::FLG_W-1:0] flag_register;
  logic [mic_pkg::NSRC-1:0][mic_pkg::CREG_W-1:0] creg;
  logic take;
  logic ack_rd;
  logic [mic_pkg::ADDR_W-1:0] ack_addr;
  logic [mic_pkg::NUM_W-1:0] ack_num;
  logic [mic_pkg::LVL_W-1:0] ack_lvl;
  logic push_vld;
  logic [mic_pkg::ADDR_W-1:0] push_data;
  logic vec_rd;
  logic [mic_pkg::ADDR_W-1:0] vec_addr;
  logic jump;
  logic [mic_pkg::ADDR_W-1:0] jump_addr;
  logic busy;
  // Driven by the CPU core end
  logic creg_wr;
  logic [mic_pkg::IDX_W-1:0] creg_idx;
  logic [mic_pkg::CREG_W-1:0] creg_wdata;
  logic [mic_pkg::CREG_W-1:0] creg_wmask;
  logic creg_move;
  logic flg_wr;
  logic [mic_pkg::FLG_W-1:0] flg_wdata;
  logic [mic_pkg::FLG_W-1:0] flg_wmask;
  logic instr_done;
  logic string_run;
  logic swi_req;
  logic [mic_pkg::NUM_W-1:0] swi_num;
  logic [mic_pkg::ADDR_W-1:0] pc;
  logic [mic_pkg::ADDR_W-1:0] vec_base;
  logic vec_ack;
  logic [mic_pkg::ADDR_W-1:0] vec_data;

  modport ctl (
    output flag_register, creg, take, ack_rd, ack_addr, ack_num, ack_lvl, push_vld,
    output push_data, vec_rd, vec_addr, jump, jump_addr, busy,
    input creg_wr, creg_idx, creg_wdata, creg_wmask, creg_move, flg_wr,
    input flg_wdata, flg_wmask, instr_done, string_run, swi_req, swi_num,
    input pc, vec_base, vec_ack, vec_data
  );

  modport cpu (
    input flag_register, creg, take, ack_rd, ack_addr, ack_num, ack_lvl, push_vld,
    input push_data, vec_rd, vec_addr, jump, jump_addr, busy,
    output creg_wr, creg_idx, creg_wdata, creg_wmask, creg_move, flg_wr,
    output flg_wdata, flg_wmask, instr_done, string_run, swi_req, swi_num,
    output pc, vec_base, vec_ack, vec_data
  );
endinterface

//--- src/mic_resolve.sv
// Priority resolution across the maskable sources
`timescale 1ns/1ps
module mic_resolve (
  input wire logic [mic_pkg::NSRC-1:0][mic_pkg::CREG_W-1:0] creg_i,
  input wire logic ien_i,
  input wire logic [mic_pkg::LVL_W-1:0] ipl_i,
  output logic hit_o,
  output logic [mic_pkg::IDX_W-1:0] idx_o,
  output logic [mic_pkg::LVL_W-1:0] lvl_o
);
  logic [mic_pkg::NSRC-1:0] elig;

  // ----------------------------------------------------------------
  // Eligibility per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < mic_pkg::NSRC; g++) begin : g_elig
      // Level 0 never beats any threshold, so it is disabled for free
      assign elig[g] = ien_i & creg_i[g][mic_pkg::REQ_BIT] &
        (creg_i[g][mic_pkg::LVL_LSB +: mic_pkg::LVL_W] > ipl_i);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Highest level wins; ties go to the lower source index
  // ----------------------------------------------------------------
  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    lvl_o = '0;
    for (int i = mic_pkg::NSRC - 1; i >= 0; i--) begin
      if (elig[i] && (!hit_o ||
          creg_i[i][mic_pkg::LVL_LSB +: mic_pkg::LVL_W] >= lvl_o)) begin
        hit_o = 1'b1;
        idx_o = mic_pkg::IDX_W'(i);
        lvl_o = creg_i[i][mic_pkg::LVL_LSB +: mic_pkg::LVL_W];
      end
    end
  end
endmodule

//--- src/mic_cpu_end.sv
// CPU core end: software register access, boundaries, vector reads
`timescale 1ns/1ps
module mic_cpu_end (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sw_creg_wr_i,
  input wire logic [mic_pkg::IDX_W-1:0] sw_creg_idx_i,
  input wire logic [mic_pkg::CREG_W-1:0] sw_creg_wdata_i,
  input wire logic [mic_pkg::CREG_W-1:0] sw_creg_wmask_i,
  input wire logic sw_creg_move_i,
  input wire logic sw_flag_set_i,
  input wire logic sw_flag_clr_i,
  input wire logic bus_hold_i,
  input wire logic instr_done_i,
  input wire logic string_run_i,
  input wire logic swi_req_i,
  input wire logic [mic_pkg::NUM_W-1:0] swi_num_i,
  input wire logic [mic_pkg::ADDR_W-1:0] pc_i,
  input wire logic [mic_pkg::ADDR_W-1:0] vec_base_i,
  input wire logic mem_ack_i,
  input wire logic [mic_pkg::ADDR_W-1:0] mem_rdata_i,
  output logic sw_ready_o,
  output logic mem_rd_o,
  output logic [mic_pkg::ADDR_W-1:0] mem_addr_o,
  output logic stack_wr_o,
  output logic [mic_pkg::ADDR_W-1:0] stack_data_o,
  output logic jump_o,
  output logic [mic_pkg::ADDR_W-1:0] jump_addr_o,
  mic_if.cpu ifc
);
  mic_pkg::mic_host_e st_q, st_d;
  logic [mic_pkg::IDX_W-1:0] idx_q, idx_d;
  logic [mic_pkg::CREG_W-1:0] wdat_q, wdat_d;
  logic [mic_pkg::CREG_W-1:0] wmsk_q, wmsk_d;
  logic move_q, move_d;
  logic [mic_pkg::GAP_W-1:0] gap_q, gap_d;
  logic setp_q, setp_d;
  logic cwr_q, cwr_d;
  logic fwr_q, fwr_d;
  logic [mic_pkg::FLG_W-1:0] fdat_q, fdat_d;
  logic [mic_pkg::FLG_W-1:0] i_mask;

  assign i_mask = mic_pkg::FLG_W'(1) << mic_pkg::FLG_I;

  // ----------------------------------------------------------------
  // Software access sequencing, next values
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    wdat_d = wdat_q;
    wmsk_d = wmsk_q;
    move_d = move_q;
    setp_d = setp_q | sw_flag_set_i;
    gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
    cwr_d = 1'b0;
    fwr_d = 1'b0;
    fdat_d = fdat_q;
    unique case (st_q)
      mic_pkg::H_IDLE: begin
        if (sw_creg_wr_i) begin
          idx_d = sw_creg_idx_i;
          wdat_d = sw_creg_wdata_i;
          // A one is never sent to the pending bit
          wmsk_d = sw_creg_wmask_i;
          wmsk_d[mic_pkg::REQ_BIT] = sw_creg_wmask_i[mic_pkg::REQ_BIT] &
            !sw_creg_wdata_i[mic_pkg::REQ_BIT];
          move_d = sw_creg_move_i;
          // Rewrite only while disabled; disable first when needed
          st_d = ifc.flag_register[mic_pkg::FLG_I] ? mic_pkg::H_DIS :
            mic_pkg::H_WR;
        end else if (sw_flag_clr_i) begin
          fwr_d = 1'b1;
          fdat_d = '0;
        end else if (setp_q && gap_q == '0 && !ifc.busy) begin
          fwr_d = 1'b1;
          fdat_d = i_mask;
          setp_d = sw_flag_set_i;
        end
      end
      mic_pkg::H_DIS: begin
        fwr_d = 1'b1;
        fdat_d = '0;
        st_d = mic_pkg::H_WR;
      end
      mic_pkg::H_WR: begin
        if (!ifc.busy) begin
          cwr_d = 1'b1;
          gap_d = bus_hold_i ? mic_pkg::GAP_NOP_HOLD :
            mic_pkg::GAP_NOP;
          st_d = mic_pkg::H_IDLE;
        end
      end
      default: begin
        st_d = mic_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= mic_pkg::H_IDLE;
      idx_q <= '0;
      wdat_q <= '0;
      wmsk_q <= '0;
      move_q <= 1'b0;
      gap_q <= '0;
      setp_q <= 1'b0;
      cwr_q <= 1'b0;
      fwr_q <= 1'b0;
      fdat_q <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      wdat_q <= wdat_d;
      wmsk_q <= wmsk_d;
      move_q <= move_d;
      gap_q <= gap_d;
      setp_q <= setp_d;
      cwr_q <= cwr_d;
      fwr_q <= fwr_d;
      fdat_q <= fdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered pass-through of core status and entry traffic
  // ----------------------------------------------------------------
  logic done_q, srun_q, swi_q, mrd_q, mack_q, swr_q, jmp_q;
  logic [mic_pkg::NUM_W-1:0] snum_q;
  logic [mic_pkg::ADDR_W-1:0] pc_q, vb_q, maddr_q, mdat_q, sdat_q, jadr_q;

  // One cycle of latency each way; the entry waits on vec_ack anyway
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      srun_q <= 1'b0;
      swi_q <= 1'b0;
      snum_q <= '0;
      pc_q <= '0;
      vb_q <= '0;
      mrd_q <= 1'b0;
      maddr_q <= '0;
      mack_q <= 1'b0;
      mdat_q <= '0;
      swr_q <= 1'b0;
      sdat_q <= '0;
      jmp_q <= 1'b0;
      jadr_q <= '0;
    end else begin
      done_q <= instr_done_i & !ifc.take;
      srun_q <= string_run_i & !ifc.take;
      swi_q <= swi_req_i & !ifc.take;
      snum_q <= swi_num_i;
      pc_q <= pc_i;
      vb_q <= vec_base_i;
      mrd_q <= ifc.vec_rd;
      maddr_q <= ifc.vec_addr;
      mack_q <= mem_ack_i;
      mdat_q <= mem_rdata_i;
      swr_q <= ifc.push_vld;
      sdat_q <= ifc.push_data;
      jmp_q <= ifc.jump;
      jadr_q <= ifc.jump_addr;
    end
  end

  assign sw_ready_o = (st_q == mic_pkg::H_IDLE) && !fwr_q;
  assign mem_rd_o = mrd_q;
  assign mem_addr_o = maddr_q;
  assign stack_wr_o = swr_q;
  assign stack_data_o = sdat_q;
  assign jump_o = jmp_q;
  assign jump_addr_o = jadr_q;
  assign ifc.creg_wr = cwr_q;
  assign ifc.creg_idx = idx_q;
  assign ifc.creg_wdata = wdat_q;
  assign ifc.creg_wmask = wmsk_q;
  assign ifc.creg_move = move_q;
  assign ifc.flg_wr = fwr_q;
  assign ifc.flg_wdata = fdat_q;
  assign ifc.flg_wmask = i_mask;
  assign ifc.instr_done = done_q;
  assign ifc.string_run = srun_q;
  assign ifc.swi_req = swi_q;
  assign ifc.swi_num = snum_q;
  assign ifc.pc = pc_q;
  assign ifc.vec_base = vb_q;
  assign ifc.vec_ack = mack_q;
  assign ifc.vec_data = mdat_q;
endmodule

//--- test/mic_chk_sva.sv
// Concurrent checks on the link between the two interrupt ends
`timescale 1ns/1ps
module mic_chk (
  input logic ref_clk_i,
  input logic rst_n_i,
  input logic [15:0] flag_register,
  input logic take,
  input logic ack_rd,
  input logic [19:0] ack_addr,
  input logic [5:0] ack_num,
  input logic [2:0] ack_lvl,
  input logic push_vld,
  input logic [19:0] push_data,
  input logic vec_rd,
  input logic [19:0] vec_addr,
  input logic jump,
  input logic [19:0] jump_addr,
  input logic [19:0] vec_base,
  input logic vec_ack,
  input logic [19:0] vec_data
);
  // ------------------------------------------------
  // Entry sequence checks
  // ------------------------------------------------
  // One clock; a reset drops any entry half watched
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  en_gate_a: assert property (take |-> $past(flag_register[0]))
    else $error("accept with enable low");
  lvl_above_a: assert property (ack_rd |-> ack_lvl > $past(flag_register[6:4]))
    else $error("level not above threshold");
  ack_read_a: assert property (ack_rd |-> $past(take) && ack_addr == 0)
    else $error("bad acknowledge read");
  flag_clr_a: assert property ($rose(push_vld) |=> flag_register[2:0] == 3'h0)
    else $error("control flags not cleared");
  // Flags stay frozen from accept until the save step copies them
  flag_push_a: assert property (take |-> ##4 push_vld &&
    push_data == {4'h0, $past(flag_register, 4)}) else $error("bad flag push");
  vec_addr_a: assert property (ack_rd |-> ##4 vec_rd &&
    vec_addr == vec_base + {ack_num, 2'h0}) else $error("bad vector");
  jump_vec_a: assert property (vec_ack |-> ##2 jump &&
    jump_addr == $past(vec_data, 2)) else $error("bad jump");
  ipl_load_a: assert property (jump |-> flag_register[6:4] == ack_lvl)
    else $error("threshold not loaded");
endmodule

//--- test/tb_maskable_interrupt_control.sv
// Bench joining the interrupt control end and the CPU core end
`timescale 1ns/1ps
module tb_maskable_interrupt_control;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr = 1'b0, flag_set_op = 1'b0, done = 1'b0, ack = 1'b0;
  logic move = 1'b0, hold = 1'b0, srun = 1'b0, rdy, mrd, busy_o;
  logic [2:0] idx = 3'h0, processor_level_threshold, lvl[8];
  logic [7:0] req = 8'h00, wdata = 8'h00, pend, pend_o;
  logic [19:0] rdata = 20'h00000, pc = 20'h00000, base = 20'h00000;
  logic [19:0] maddr, exp_q[$];
  int unsigned seed = 37769;
  int n_errors = 0;
  int num_checks = 0;
  mic_if ifc();
  maskable_interrupt_control maskable_interrupt_control_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .src_req_i(req),
    .src_pend_o(pend_o), .busy_o(busy_o), .ifc(ifc));
  mic_cpu_end mic_cpu_end_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sw_creg_wr_i(wr), .sw_creg_idx_i(idx), .sw_creg_wdata_i(wdata),
    .sw_creg_wmask_i(8'h0F), .sw_creg_move_i(move), .sw_flag_set_i(flag_set_op),
    .sw_flag_clr_i(1'b0), .bus_hold_i(hold), .instr_done_i(done),
    .string_run_i(srun), .swi_req_i(1'b0), .swi_num_i(6'h00), .pc_i(pc),
    .vec_base_i(base), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .sw_ready_o(rdy), .mem_rd_o(mrd), .mem_addr_o(maddr), .stack_wr_o(),
    .stack_data_o(), .jump_o(), .jump_addr_o(), .ifc(ifc));
  mic_chk mic_chk_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .flag_register(ifc.flag_register), .take(ifc.take), .ack_rd(ifc.ack_rd),
    .ack_addr(ifc.ack_addr), .ack_num(ifc.ack_num), .ack_lvl(ifc.ack_lvl),
    .push_vld(ifc.push_vld), .push_data(ifc.push_data),
    .vec_rd(ifc.vec_rd), .vec_addr(ifc.vec_addr), .jump(ifc.jump),
    .jump_addr(ifc.jump_addr), .vec_base(ifc.vec_base),
    .vec_ack(ifc.vec_ack), .vec_data(ifc.vec_data));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [19:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 20'(seed);
  endfunction
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Inputs always move one step after the edge
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  // Every wait is bounded; running out ends the run
  task automatic bump(inout int k);
    tick();
    k++;
    if (k > 80) begin
      n_errors++;
      print_verdict();
    end
  endtask
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  // Core memory side: answers vector reads against the oldest note
  initial begin
    forever begin
      // Look once the read strobe has settled after its launching edge
      @(posedge ref_clk_i);
      #1;
      if (mrd === 1'b1) begin
        chk(maddr, exp_q.size() > 0 ? exp_q.pop_front() : ~maddr);
        ack = 1'b1;
        rdata = rnd();
        tick();
        ack = 1'b0;
      end
    end
  end
  // Each round: reset, random levels, random requests, two passes with at most one entry
  initial begin
    int w;
    int k;
    for (int r = 0; r < 8; r++) begin
      rst_n_i = 1'b0;
      repeat (8) tick();
      rst_n_i = 1'b1;
      processor_level_threshold = 3'h0;
      pc = rnd();
      base = rnd();
      hold = 1'(rnd());
      // Bit 3 written as one must not raise the pending bit
      for (int i = 0; i < 8; i++) begin
        lvl[i] = 3'(rnd());
        k = 0;
        while (rdy !== 1'b1) bump(k);
        wr = 1'b1;
        idx = 3'(i);
        wdata = {4'h0, 1'(rnd()), lvl[i]};
        move = 1'(rnd());
        tick();
        wr = 1'b0;
      end
      // Let the last rewrite land so its pending clear cannot eat a request
      repeat (3) tick();
      req = 8'(rnd());
      pend = req;
      tick();
      req = 8'h00;
      for (int a = 0; a < 2; a++) begin
        // Strict compare keeps the lower index on equal levels
        w = -1;
        for (int i = 0; i < 8; i++) begin
          if (pend[i] && lvl[i] > processor_level_threshold && (w < 0 || lvl[i] > lvl[w])) w = i;
        end
        if (w >= 0) begin
          exp_q.push_back(base + 20'(4 * (4 + w)));
          pend[w] = 1'b0;
          processor_level_threshold = lvl[w];
        end
        srun = 1'(rnd());
        flag_set_op = 1'b1;
        tick();
        flag_set_op = 1'b0;
        k = 0;
        while (ifc.flag_register[0] !== 1'b1 && busy_o !== 1'b1) bump(k);
        done = 1'b1;
        tick();
        done = 1'b0;
        k = 0;
        while (exp_q.size() > 0 || busy_o !== 1'b0) bump(k);
        tick();
        chk(20'(pend_o), 20'(pend));
        chk(20'(ifc.flag_register[6:4]), 20'(processor_level_threshold));
      end
      srun = 1'b0;
      $display("round %0d done", r);
    end
    print_verdict();
  end
endmodule
